// >>> design/fsnv_cfg.svh
// offsets, field widths and reset values of the fail-safe / diagnostics config bank
`ifndef FSNV_CFG_SVH
`define FSNV_CFG_SVH

// ****************************************************************
// register indices (printed offsets are not word multiples)
// ****************************************************************
`define FSNV_IDX_FS0_LOW 8'hC0
`define FSNV_IDX_FS0_HIGH 8'hC1
`define FSNV_IDX_FS1_LOW 8'hC2
`define FSNV_IDX_FS1_HIGH 8'hC3
`define FSNV_IDX_DIAG_LOW 8'hC4
`define FSNV_IDX_DIAG_HIGH 8'hC5

// ****************************************************************
// field layout and reset values
// ****************************************************************
`define FSNV_LOW_W 8
`define FSNV_HIGH_W 4
`define FSNV_RST_FS0_LOW 8'h00
`define FSNV_RST_FS0_HIGH 4'h0
`define FSNV_RST_FS1_LOW 8'hFF
`define FSNV_RST_FS1_HIGH 4'hF
`define FSNV_RST_DIAG_LOW 8'hFF
`define FSNV_RST_DIAG_HIGH 4'hF

// ****************************************************************
// bus answers
// ****************************************************************
`define FSNV_RESP_OKAY 2'h0
`define FSNV_RESP_SLVERR 2'h2

`endif

// >>> design/fsnv_pkg.sv
// types shared by the fail-safe / diagnostics config bank
package fsnv_pkg;
   typedef logic [1:0] fsnv_resp_t;
   typedef logic [11:0] fsnv_chan_mask_t;
endpackage

// >>> design/fsnv_bank.sv
// fail-safe and diagnostics enable register bank behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "fsnv_cfg.svh"

module fsnv_bank #(
   parameter int ADDR_W = 12
) (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output fsnv_pkg::fsnv_resp_t o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output fsnv_pkg::fsnv_resp_t o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output fsnv_pkg::fsnv_chan_mask_t o_safe_state_zero_on,
   output fsnv_pkg::fsnv_chan_mask_t o_safe_state_one_on,
   output fsnv_pkg::fsnv_chan_mask_t o_stored_diag_on
);
   import fsnv_pkg::*;

   // the top register sits at byte address 314h, which needs ten address bits
   if (ADDR_W < 10)
   begin
      $error("ADDR_W too small for the register map");
   end

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [`FSNV_LOW_W-1:0] failsafe0_enable_low;
   logic [`FSNV_HIGH_W-1:0] failsafe0_enable_high;
   logic [`FSNV_LOW_W-1:0] failsafe1_enable_low;
   logic [`FSNV_HIGH_W-1:0] failsafe1_enable_high;
   logic [`FSNV_LOW_W-1:0] diagnostics_enable_low;
   logic [`FSNV_HIGH_W-1:0] diagnostics_enable_high;

   // ****************************************************************
   // write channel: address and data taken in either order
   // ****************************************************************
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic w_lane0;
   logic do_write;
   logic [ADDR_W-3:0] w_idx;
   logic w_hit;

   assign do_write = aw_held && w_held && !o_bvalid;
   assign w_idx = aw_addr[ADDR_W-1:2];
   // only byte lane 0 carries data; upper lanes are reserved
   assign w_hit = (aw_addr[1:0] == 2'h0)
      && (w_idx >= (ADDR_W-2)'(`FSNV_IDX_FS0_LOW))
      && (w_idx <= (ADDR_W-2)'(`FSNV_IDX_DIAG_HIGH));

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         o_awready <= 1'b0;
      end
      else
      begin
         // readies stay low while an answer waits, so no second write queues behind it
         o_awready <= !aw_held && !o_bvalid && !(i_awvalid && o_awready);
         if (i_awvalid && o_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
            o_awready <= 1'b0;
         end
         else if (do_write)
         begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         w_held <= 1'b0;
         w_data <= '0;
         w_lane0 <= 1'b0;
         o_wready <= 1'b0;
      end
      else
      begin
         o_wready <= !w_held && !o_bvalid && !(i_wvalid && o_wready);
         if (i_wvalid && o_wready)
         begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_lane0 <= i_wstrb[0];
         end
         else if (do_write)
         begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_bvalid <= 1'b0;
         o_bresp <= `FSNV_RESP_OKAY;
      end
      else if (do_write)
      begin
         o_bvalid <= 1'b1;
         o_bresp <= w_hit ? `FSNV_RESP_OKAY : `FSNV_RESP_SLVERR;
      end
      else if (i_bready)
      begin
         o_bvalid <= 1'b0;
      end
   end

   // a write only lands when lane 0 is strobed; bits above the 8- or 4-bit field are dropped
   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         failsafe0_enable_low <= `FSNV_RST_FS0_LOW;
         failsafe0_enable_high <= `FSNV_RST_FS0_HIGH;
         failsafe1_enable_low <= `FSNV_RST_FS1_LOW;
         failsafe1_enable_high <= `FSNV_RST_FS1_HIGH;
         diagnostics_enable_low <= `FSNV_RST_DIAG_LOW;
         diagnostics_enable_high <= `FSNV_RST_DIAG_HIGH;
      end
      else if (do_write && w_hit && w_lane0)
      begin
         unique case (w_idx)
            (ADDR_W-2)'(`FSNV_IDX_FS0_LOW): failsafe0_enable_low <= w_data[7:0];
            (ADDR_W-2)'(`FSNV_IDX_FS0_HIGH): failsafe0_enable_high <= w_data[3:0];
            (ADDR_W-2)'(`FSNV_IDX_FS1_LOW): failsafe1_enable_low <= w_data[7:0];
            (ADDR_W-2)'(`FSNV_IDX_FS1_HIGH): failsafe1_enable_high <= w_data[3:0];
            (ADDR_W-2)'(`FSNV_IDX_DIAG_LOW): diagnostics_enable_low <= w_data[7:0];
            (ADDR_W-2)'(`FSNV_IDX_DIAG_HIGH): diagnostics_enable_high <= w_data[3:0];
            default:
            begin
            end
         endcase
      end
   end

   // ****************************************************************
   // read channel
   // ****************************************************************
   logic [ADDR_W-3:0] r_idx;
   logic [31:0] next_rdata;
   logic r_hit;

   assign r_idx = i_araddr[ADDR_W-1:2];

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      r_hit = (i_araddr[1:0] == 2'h0);
      unique case (r_idx)
         (ADDR_W-2)'(`FSNV_IDX_FS0_LOW): next_rdata[7:0] = failsafe0_enable_low;
         (ADDR_W-2)'(`FSNV_IDX_FS0_HIGH): next_rdata[3:0] = failsafe0_enable_high;
         (ADDR_W-2)'(`FSNV_IDX_FS1_LOW): next_rdata[7:0] = failsafe1_enable_low;
         (ADDR_W-2)'(`FSNV_IDX_FS1_HIGH): next_rdata[3:0] = failsafe1_enable_high;
         (ADDR_W-2)'(`FSNV_IDX_DIAG_LOW): next_rdata[7:0] = diagnostics_enable_low;
         (ADDR_W-2)'(`FSNV_IDX_DIAG_HIGH): next_rdata[3:0] = diagnostics_enable_high;
         default: r_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= `FSNV_RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rdata <= r_hit ? next_rdata : 32'h0000_0000;
         o_rresp <= r_hit ? `FSNV_RESP_OKAY : `FSNV_RESP_SLVERR;
      end
      else if (o_rvalid)
      begin
         if (i_rready)
         begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
      else
      begin
         o_arready <= 1'b1;
      end
   end

   // ****************************************************************
   // channel enables to the output stage and diagnostics
   // ****************************************************************
   // a set bit lets the channel run in that fail-safe state
   always_ff @(posedge i_sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_safe_state_zero_on <= {`FSNV_RST_FS0_HIGH, `FSNV_RST_FS0_LOW};
         o_safe_state_one_on <= {`FSNV_RST_FS1_HIGH, `FSNV_RST_FS1_LOW};
         o_stored_diag_on <= {`FSNV_RST_DIAG_HIGH, `FSNV_RST_DIAG_LOW};
      end
      else
      begin
         o_safe_state_zero_on <= {failsafe0_enable_high, failsafe0_enable_low};
         o_safe_state_one_on <= {failsafe1_enable_high, failsafe1_enable_low};
         o_stored_diag_on <= {diagnostics_enable_high, diagnostics_enable_low};
      end
   end
endmodule

// >>> tb/fsnv_bank_assertions.sv
// concurrent checks on the fail-safe / diagnostics config bank ports
`timescale 1ns/100ps
module fsnv_bank_assertions
   import fsnv_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire fsnv_pkg::fsnv_resp_t o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire fsnv_pkg::fsnv_chan_mask_t o_safe_state_zero_on,
   input wire fsnv_pkg::fsnv_chan_mask_t o_safe_state_one_on,
   input wire fsnv_pkg::fsnv_chan_mask_t o_stored_diag_on
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   // internal reset lingers two edges, so the first edge still shows reset values
   chk_rst_values: assert property ($rose(i_resetn) |-> o_safe_state_zero_on == 12'h000
      && o_safe_state_one_on == 12'hFFF && o_stored_diag_on == 12'hFFF)
      else $error("enable reset values wrong");
   chk_bresp_stand: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped");
   chk_rdata_stand: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
   chk_ready_hold: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write ready during answer");
   chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("read answer late");
   chk_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
      |-> ##2 o_bvalid) else $error("write answer late");
   chk_rsvd_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
      else $error("reserved bits not zero");
   // enables move only in the cycle after a write completes
   chk_enable_cause: assert property ($changed({o_safe_state_zero_on, o_safe_state_one_on,
      o_stored_diag_on}) |-> $past(o_bvalid)) else $error("enable moved without write");
   cover property (o_bvalid && i_bready && o_bresp == 2'h2);
   cover property (o_bvalid && i_bready && o_bresp == 2'h0);
   cover property (o_rvalid && i_rready);
endmodule
bind fsnv_bank fsnv_bank_assertions u_chk (
   .i_sys_clk(i_sys_clk),
   .i_resetn(i_resetn),
   .i_awvalid(i_awvalid),
   .o_awready(o_awready),
   .i_wvalid(i_wvalid),
   .o_wready(o_wready),
   .o_bresp(o_bresp),
   .o_bvalid(o_bvalid),
   .i_bready(i_bready),
   .i_arvalid(i_arvalid),
   .o_arready(o_arready),
   .o_rdata(o_rdata),
   .o_rvalid(o_rvalid),
   .i_rready(i_rready),
   .o_safe_state_zero_on(o_safe_state_zero_on),
   .o_safe_state_one_on(o_safe_state_one_on),
   .o_stored_diag_on(o_stored_diag_on)
);

// >>> tb/fsnv_bank_tb_top.sv
// self-checking bench for the fail-safe / diagnostics config bank
`timescale 1ns/100ps
`include "fsnv_cfg.svh"
module fsnv_bank_tb_top;
   import fsnv_pkg::*;
   logic i_sys_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [11:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0] i_wstrb;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   fsnv_resp_t o_bresp, o_rresp;
   fsnv_chan_mask_t o_safe_state_zero_on, o_safe_state_one_on, o_stored_diag_on;
   int fail_count = 0;
   int n_tests = 0;
   fsnv_bank dut (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_safe_state_zero_on(o_safe_state_zero_on),
      .o_safe_state_one_on(o_safe_state_one_on),
      .o_stored_diag_on(o_stored_diag_on)
   );
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [11:0] adr(input int i);
      return 12'(4 * (`FSNV_IDX_FS0_LOW + i));
   endfunction
   // late holds bready back for that many cycles of bvalid, so the answer must stand
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input fsnv_resp_t r, input int late = 0);
      int seen = 0;
      @(posedge i_sys_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= s;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= (late == 0);
      do
      begin
         @(posedge i_sys_clk);
         if (i_awvalid && o_awready)
            i_awvalid <= 1'b0;
         if (i_wvalid && o_wready)
            i_wvalid <= 1'b0;
         if (o_bvalid === 1'b1)
            seen++;
         if (seen >= late && i_bready !== 1'b1)
            i_bready <= 1'b1;
      end
      while (!(o_bvalid === 1'b1 && i_bready === 1'b1));
      i_bready <= 1'b0;
      chk("bresp", 32'(r), 32'(o_bresp));
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input fsnv_resp_t r,
      input int late = 0);
      int seen = 0;
      @(posedge i_sys_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= (late == 0);
      do
      begin
         @(posedge i_sys_clk);
         if (i_arvalid && o_arready)
            i_arvalid <= 1'b0;
         if (o_rvalid === 1'b1)
            seen++;
         if (seen >= late && i_rready !== 1'b1)
            i_rready <= 1'b1;
      end
      while (!(o_rvalid === 1'b1 && i_rready === 1'b1));
      i_rready <= 1'b0;
      chk("rdata", e, o_rdata);
      chk("rresp", 32'(r), 32'(o_rresp));
   endtask
   // same value into all six registers, so every enable vector is {e[3:0], e}
   task automatic sweep(input logic [31:0] d, input logic [3:0] s, input logic [7:0] e);
      for (int i = 0; i < 6; i++)
      begin
         wr(adr(i), d, s, `FSNV_RESP_OKAY);
         rd(adr(i), (i % 2) ? 32'(e[3:0]) : 32'(e), `FSNV_RESP_OKAY);
      end
      chk("zero_on", 32'({e[3:0], e}), 32'(o_safe_state_zero_on));
      chk("one_on", 32'({e[3:0], e}), 32'(o_safe_state_one_on));
      chk("diag_on", 32'({e[3:0], e}), 32'(o_stored_diag_on));
   endtask
   // reset values of all six registers and of the three enable vectors
   task automatic rst_vals();
      logic [31:0] e;
      for (int i = 0; i < 6; i++)
      begin
         e = (i < 2) ? 32'h0 : ((i % 2) ? 32'hF : 32'hFF);
         rd(adr(i), e, `FSNV_RESP_OKAY);
      end
      chk("zero_on", 32'h0000_0000, 32'(o_safe_state_zero_on));
      chk("one_on", 32'h0000_0FFF, 32'(o_safe_state_one_on));
      chk("diag_on", 32'h0000_0FFF, 32'(o_stored_diag_on));
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   // a full run needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge i_sys_clk);
      fail_count++;
      conclude();
   end
   initial
   begin
      {i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
      {i_awaddr, i_araddr, i_wdata, i_wstrb} = 60'h0;
      repeat (12) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      rst_vals();
      $display("reset values done");
      sweep(32'hFFFF_FFA5, 4'hF, 8'hA5);
      $display("pattern write done");
      sweep(32'hFFFF_FF00, 4'hF, 8'h00);
      $display("clear write done");
      sweep(32'h0000_00FF, 4'hE, 8'h00);
      $display("masked write done");
      // answers held back a few cycles: they must stand until taken
      wr(adr(0), 32'h0000_005A, 4'h1, `FSNV_RESP_OKAY, 3);
      rd(adr(0), 32'h0000_005A, `FSNV_RESP_OKAY, 3);
      chk("zero_on", 32'h0000_005A, 32'(o_safe_state_zero_on));
      $display("slow answer done");
      @(posedge i_sys_clk);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      rst_vals();
      $display("mid-run reset done");
      wr(12'h318, 32'hF, 4'hF, `FSNV_RESP_SLVERR);
      rd(12'h318, 32'h0, `FSNV_RESP_SLVERR);
      rd(12'h301, 32'h0, `FSNV_RESP_SLVERR);
      $display("unmapped access done");
      conclude();
   end
endmodule
